//--- tmw_pkg.sv
// Constants and types shared by the 8-bit waveform timer files
package tmw_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_COUNT = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_FLAGS = 3'h3;
  localparam logic [2:0] ADDR_PORT = 3'h4;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int PORT_DATA_BIT = 0;
  localparam int PORT_STATE_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Prescaler divide factors
  // ----------------------------------------------------------------
  localparam int PRESCALE_W = 10;
  localparam logic [PRESCALE_W-1:0] DIV1_MASK = 10'h000;
  localparam logic [PRESCALE_W-1:0] DIV8_MASK = 10'h007;
  localparam logic [PRESCALE_W-1:0] DIV32_MASK = 10'h01f;
  localparam logic [PRESCALE_W-1:0] DIV64_MASK = 10'h03f;
  localparam logic [PRESCALE_W-1:0] DIV128_MASK = 10'h07f;
  localparam logic [PRESCALE_W-1:0] DIV256_MASK = 10'h0ff;
  localparam logic [PRESCALE_W-1:0] DIV1024_MASK = 10'h3ff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMW_MODE_NORMAL = 2'h0,
    TMW_MODE_PHASE = 2'h1,
    TMW_MODE_CLEAR = 2'h2,
    TMW_MODE_FAST = 2'h3
  } tmw_mode_t;

  typedef enum logic [1:0] {
    TMW_OUT_NONE = 2'h0,
    TMW_OUT_TOGGLE = 2'h1,
    TMW_OUT_CLEAR = 2'h2,
    TMW_OUT_SET = 2'h3
  } tmw_out_mode_t;

  typedef struct packed {
    logic dir;
    logic [2:0] clk_sel;
    tmw_out_mode_t output_mode;
    tmw_mode_t mode_select;
  } tmw_ctrl_t;

endpackage

//--- tmw_prescaler.sv
// Timer clock enable derived from the I/O clock
module tmw_prescaler (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Divide select, zero stops the timer
  input wire logic [2:0] clk_sel_in,
  // Timer clock enable
  output logic tick_out
);

  // ----------------------------------------------------------------
  // Divide decode
  // ----------------------------------------------------------------
  function automatic logic [tmw_pkg::PRESCALE_W-1:0] div_mask(input logic [2:0] sel);
    unique case (sel)
      3'h1: div_mask = tmw_pkg::DIV1_MASK;
      3'h2: div_mask = tmw_pkg::DIV8_MASK;
      3'h3: div_mask = tmw_pkg::DIV32_MASK;
      3'h4: div_mask = tmw_pkg::DIV64_MASK;
      3'h5: div_mask = tmw_pkg::DIV128_MASK;
      3'h6: div_mask = tmw_pkg::DIV256_MASK;
      3'h7: div_mask = tmw_pkg::DIV1024_MASK;
      default: div_mask = tmw_pkg::DIV1_MASK;
    endcase
  endfunction

  logic [tmw_pkg::PRESCALE_W-1:0] div_count;
  logic [tmw_pkg::PRESCALE_W-1:0] mask;

  assign mask = div_mask(clk_sel_in);
  // Divider held at zero while stopped, so a restart is predictable
  assign tick_out = (clk_sel_in != 3'h0) && ((div_count & mask) == mask);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || clk_sel_in == 3'h0) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 10'h001;
    end
  end

endmodule

//--- tmw_pin_stage.sv
// Port pin multiplexer for the compare output
module tmw_pin_stage (
  // Controls
  input wire tmw_pkg::tmw_out_mode_t output_mode_in,
  input wire logic dir_in,
  // Sources
  input wire logic oc_state_in,
  input wire logic port_data_in,
  // Pin
  output logic pin_out,
  output logic pin_oe_out
);

  // ----------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------
  // Any non-zero output mode overrides the general port function
  assign pin_out = (output_mode_in != tmw_pkg::TMW_OUT_NONE) ? oc_state_in : port_data_in;
  // Direction alone decides whether the pin is driven
  assign pin_oe_out = dir_in;

endmodule

//--- tmw_timer.sv
// 8-bit timer with clear-on-match, fast PWM and phase-correct PWM
module tmw_timer (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [tmw_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [tmw_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [tmw_pkg::DATA_W-1:0] reg_rdata_out,
  // Compare output pin
  output logic compare_output_out,
  output logic compare_output_oe_out,
  // Status
  output logic overflow_flag_out,
  output logic compare_flag_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tmw_pkg::tmw_ctrl_t ctrl;
  logic [7:0] count_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buf;
  logic dir_up;
  logic block_match;
  logic overflow_flag;
  logic compare_flag;
  logic oc_state;
  logic port_data;
  logic [7:0] rdata;
  logic tick;
  logic pwm_mode;
  logic match;
  logic at_max;
  logic at_bottom;
  logic load_compare;
  logic up_side;
  logic [7:0] next_count;
  logic next_dir;
  logic next_oc;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_port;
  logic set_ovf;
  logic set_cmp;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [tmw_pkg::ADDR_W-1:0] a,
                                    input logic [tmw_pkg::ADDR_W-1:0] reg_a);
    addr_hit = (a == reg_a);
  endfunction

  // Level that a compare match leaves, given the slope it occurs on
  function automatic logic slope_level(input tmw_pkg::tmw_out_mode_t om,
                                       input logic up);
    slope_level = (om == tmw_pkg::TMW_OUT_SET) ? up : ~up;
  endfunction

  assign wr_ctrl = reg_wr_in && addr_hit(reg_addr_in, tmw_pkg::ADDR_CTRL);
  assign wr_count = reg_wr_in && addr_hit(reg_addr_in, tmw_pkg::ADDR_COUNT);
  assign wr_compare = reg_wr_in && addr_hit(reg_addr_in, tmw_pkg::ADDR_COMPARE);
  assign wr_flags = reg_wr_in && addr_hit(reg_addr_in, tmw_pkg::ADDR_FLAGS);
  assign wr_port = reg_wr_in && addr_hit(reg_addr_in, tmw_pkg::ADDR_PORT);

  // ----------------------------------------------------------------
  // Timer clock
  // ----------------------------------------------------------------
  tmw_prescaler u_prescaler (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .clk_sel_in(ctrl.clk_sel),
    .tick_out(tick)
  );

  // ----------------------------------------------------------------
  // Control and port data registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl <= tmw_pkg::tmw_ctrl_t'(tmw_pkg::CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl <= tmw_pkg::tmw_ctrl_t'(reg_wdata_in);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      port_data <= 1'b0;
    end else if (wr_port) begin
      port_data <= reg_wdata_in[tmw_pkg::PORT_DATA_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  assign pwm_mode = (ctrl.mode_select == tmw_pkg::TMW_MODE_PHASE) ||
                    (ctrl.mode_select == tmw_pkg::TMW_MODE_FAST);
  assign at_max = (count_value == tmw_pkg::CNT_MAX);
  assign at_bottom = (count_value == tmw_pkg::CNT_BOTTOM);
  // A count write masks the match of the next timer clock
  assign match = tick && !block_match && (count_value == compare_value);
  // Bottom counts as up-slope and MAX as down-slope, giving the extremes
  assign up_side = at_bottom ? 1'b1 : (at_max ? 1'b0 : dir_up);
  // Both PWM modes reload at MAX; in fast PWM that is the step to bottom
  assign load_compare = pwm_mode && tick && at_max;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      block_match <= 1'b0;
    end else if (wr_count) begin
      block_match <= 1'b1;
    end else if (tick) begin
      block_match <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Compare value and its buffer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      compare_buf <= tmw_pkg::COMPARE_RESET;
    end else if (wr_compare) begin
      compare_buf <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      compare_value <= tmw_pkg::COMPARE_RESET;
    end else if (wr_compare && !pwm_mode) begin
      // No buffering here: a value below the count waits for a wrap
      compare_value <= reg_wdata_in;
    end else if (load_compare) begin
      compare_value <= compare_buf;
    end
  end

  // ----------------------------------------------------------------
  // Counter sequence
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count_value;
    next_dir = dir_up;
    if (tick) begin
      unique case (ctrl.mode_select)
        tmw_pkg::TMW_MODE_CLEAR: begin
          if (match) begin
            next_count = tmw_pkg::CNT_BOTTOM;
          end else begin
            next_count = count_value + tmw_pkg::CNT_STEP;
          end
          next_dir = 1'b1;
        end
        tmw_pkg::TMW_MODE_FAST: begin
          // Natural 8-bit wrap gives 256 steps per period
          next_count = count_value + tmw_pkg::CNT_STEP;
          next_dir = 1'b1;
        end
        tmw_pkg::TMW_MODE_PHASE: begin
          if (dir_up && at_max) begin
            next_dir = 1'b0;
            next_count = count_value - tmw_pkg::CNT_STEP;
          end else if (!dir_up && at_bottom) begin
            next_dir = 1'b1;
            next_count = count_value + tmw_pkg::CNT_STEP;
          end else if (dir_up) begin
            next_count = count_value + tmw_pkg::CNT_STEP;
          end else begin
            next_count = count_value - tmw_pkg::CNT_STEP;
          end
        end
        default: begin
          next_count = count_value + tmw_pkg::CNT_STEP;
          next_dir = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      count_value <= tmw_pkg::COUNT_RESET;
    end else if (wr_count) begin
      count_value <= reg_wdata_in;
    end else begin
      count_value <= next_count;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      dir_up <= 1'b1;
    end else if (ctrl.mode_select != tmw_pkg::TMW_MODE_PHASE) begin
      dir_up <= 1'b1;
    end else begin
      dir_up <= next_dir;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_comb begin
    set_ovf = 1'b0;
    if (tick) begin
      unique case (ctrl.mode_select)
        tmw_pkg::TMW_MODE_PHASE: set_ovf = at_bottom;
        tmw_pkg::TMW_MODE_FAST: set_ovf = at_max;
        default: set_ovf = at_max && (next_count == tmw_pkg::CNT_BOTTOM);
      endcase
    end
  end

  // The match ends the timer clock it occurs in, so the flag rises at its edge
  assign set_cmp = match;

  // A set in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= set_ovf ||
                       (overflow_flag && !(wr_flags && reg_wdata_in[tmw_pkg::FLAG_OVF_BIT]));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      compare_flag <= 1'b0;
    end else begin
      compare_flag <= set_cmp ||
                      (compare_flag && !(wr_flags && reg_wdata_in[tmw_pkg::FLAG_CMP_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Waveform generator
  // ----------------------------------------------------------------
  always_comb begin
    next_oc = oc_state;
    if (tick) begin
      unique case (ctrl.mode_select)
        tmw_pkg::TMW_MODE_FAST: begin
          if (match && ctrl.output_mode == tmw_pkg::TMW_OUT_TOGGLE) begin
            next_oc = ~oc_state;
          end else if (match && ctrl.output_mode[1]) begin
            next_oc = (ctrl.output_mode == tmw_pkg::TMW_OUT_SET);
          end
          // Wrap action after match, so compare at MAX gives a steady level
          if (at_max && ctrl.output_mode[1]) begin
            next_oc = (ctrl.output_mode == tmw_pkg::TMW_OUT_CLEAR);
          end
        end
        tmw_pkg::TMW_MODE_PHASE: begin
          if (match && ctrl.output_mode[1]) begin
            next_oc = slope_level(ctrl.output_mode, up_side);
          end
          // Level at MAX must match the up-slope result once compare leaves MAX
          if (at_max && ctrl.output_mode[1] && compare_buf != tmw_pkg::CNT_MAX) begin
            next_oc = slope_level(ctrl.output_mode, 1'b1);
          end
        end
        default: begin
          if (match) begin
            unique case (ctrl.output_mode)
              tmw_pkg::TMW_OUT_TOGGLE: next_oc = ~oc_state;
              tmw_pkg::TMW_OUT_CLEAR: next_oc = 1'b0;
              tmw_pkg::TMW_OUT_SET: next_oc = 1'b1;
              tmw_pkg::TMW_OUT_NONE: next_oc = oc_state;
            endcase
          end
        end
      endcase
    end
  end

  // Output state survives mode changes and a disabled pin
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      oc_state <= 1'b0;
    end else begin
      oc_state <= next_oc;
    end
  end

  tmw_pin_stage u_pin_stage (
    .output_mode_in(ctrl.output_mode),
    .dir_in(ctrl.dir),
    .oc_state_in(oc_state),
    .port_data_in(port_data),
    .pin_out(compare_output_out),
    .pin_oe_out(compare_output_oe_out)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rdata <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        tmw_pkg::ADDR_CTRL: rdata <= ctrl;
        tmw_pkg::ADDR_COUNT: rdata <= count_value;
        tmw_pkg::ADDR_COMPARE: rdata <= compare_buf;
        tmw_pkg::ADDR_FLAGS: rdata <= {6'h00, compare_flag, overflow_flag};
        tmw_pkg::ADDR_PORT: rdata <= {6'h00, oc_state, port_data};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata;
  assign overflow_flag_out = overflow_flag;
  assign compare_flag_out = compare_flag;

endmodule

//--- tmw_load_model.sv
// Behavioural load on the compare output pin
module tmw_load_model (
  // Clock and pin
  input wire logic ref_clk_in,
  input wire logic pin_in,
  input wire logic pin_oe_in,
  // Measurement
  input wire logic clr_in,
  output logic line_out,
  output logic [15:0] high_cnt_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-down holds the line low while the pin floats
  assign line_out = pin_oe_in ? pin_in : 1'b0;
  // Counts high cycles; a window that is whole periods is phase independent
  always @(posedge ref_clk_in) begin
    if (clr_in) begin
      high_cnt_out <= 16'h0000;
    end else if (line_out) begin
      high_cnt_out <= high_cnt_out + 16'h0001;
    end
  end
endmodule

//--- tmw_timer_sva.sv
// Port-level assertions for the waveform timer
module tmw_timer_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [tmw_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [tmw_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [tmw_pkg::DATA_W-1:0] reg_rdata_out,
  // Pin and status
  input wire logic compare_output_out,
  input wire logic compare_output_oe_out,
  input wire logic overflow_flag_out,
  input wire logic compare_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] cmp;
  logic port_bit;
  logic pin_q;
  logic [10:0] age;
  logic [9:0] gap;
  wire logic rose_w = compare_output_out && !pin_q;
  // Periods are judged only once transients after a write have died out
  wire logic settled = age > 11'h258;
  wire logic long_settled = age > 11'h44c;
  wire logic wr_ctrl = reg_wr_in && reg_addr_in == tmw_pkg::ADDR_CTRL;
  wire logic clr_ovf = reg_wr_in && reg_addr_in == tmw_pkg::ADDR_FLAGS && reg_wdata_in[0];
  wire logic clr_cmp = reg_wr_in && reg_addr_in == tmw_pkg::ADDR_FLAGS && reg_wdata_in[1];
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl <= tmw_pkg::CTRL_RESET;
      cmp <= tmw_pkg::COMPARE_RESET;
      port_bit <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == tmw_pkg::ADDR_CTRL) ctrl <= reg_wdata_in;
      if (reg_addr_in == tmw_pkg::ADDR_COMPARE) cmp <= reg_wdata_in;
      if (reg_addr_in == tmw_pkg::ADDR_PORT) port_bit <= reg_wdata_in[0];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || reg_wr_in) begin
      age <= 11'h000;
    end else if (age != 11'h7ff) begin
      age <= age + 11'h001;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pin_q <= 1'b0;
      gap <= 10'h000;
    end else begin
      pin_q <= compare_output_out;
      if (rose_w) gap <= 10'h001;
      else if (gap != 10'h3ff) gap <= gap + 10'h001;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  pin_enable_a: assert property (wr_ctrl |=> compare_output_oe_out == $past(reg_wdata_in[7]))
    else $error("pin enable differs from direction bit");
  port_pass_a: assert property (ctrl[3:2] == 2'h0 |-> compare_output_out == port_bit)
    else $error("pin not showing port data");
  stop_quiet_a: assert property (ctrl[6:4] == 3'h0 [*2] |=> !$rose(overflow_flag_out) && !$rose(compare_flag_out))
    else $error("flag rose with timer stopped");
  ovf_hold_a: assert property (overflow_flag_out && !clr_ovf |=> overflow_flag_out)
    else $error("overflow flag dropped");
  cmp_hold_a: assert property (compare_flag_out && !clr_cmp |=> compare_flag_out)
    else $error("compare flag dropped");
  fast_period_a: assert property (rose_w && settled && ctrl[6:4] == 3'h1 && ctrl[3] && ctrl[1:0] == 2'h3
    |-> gap == 10'h100) else $error("fast pwm period wrong");
  phase_period_a: assert property (rose_w && long_settled && ctrl[6:4] == 3'h1 && ctrl[3] && ctrl[1:0] == 2'h1
    |-> gap == 10'h1fe) else $error("phase pwm period wrong");
  ctc_period_a: assert property (rose_w && settled && ctrl[6:0] == 7'h16 |-> gap == {1'b0, cmp, 1'b0} + 10'h002)
    else $error("toggle period wrong");
  phase_low_a: assert property (long_settled && ctrl[6:0] == 7'h19 && cmp == 8'h00 |-> !compare_output_out)
    else $error("phase pwm not held low");
  cmp_readback_a: assert property (reg_rd_in && reg_addr_in == tmw_pkg::ADDR_COMPARE |=> reg_rdata_out == cmp)
    else $error("compare read differs from last write");
  cover property (rose_w && ctrl[1:0] == 2'h1);
  cover property ($rose(overflow_flag_out));
  cover property ($rose(compare_flag_out));
endmodule
bind tmw_timer tmw_timer_sva tmw_timer_sva_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .compare_output_out(compare_output_out),
  .compare_output_oe_out(compare_output_oe_out), .overflow_flag_out(overflow_flag_out),
  .compare_flag_out(compare_flag_out));

//--- tb_tmw_timer.sv
// Self-checking bench for the waveform timer
module tb_tmw_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clr = 1'b0;
  logic [7:0] reg_rdata;
  logic pin, pin_oe, ovf, cmpf, line;
  logic [15:0] high_cnt, hi;
  logic [7:0] lvl[3] = '{8'h00, 8'h40, 8'hff};
  logic [7:0] ctc_c[3] = '{8'h00, 8'h03, 8'h09};
  int div_n[7] = '{1, 8, 32, 64, 128, 256, 1024};
  int err_total = 0;
  int check_count = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  tmw_timer tmw_timer_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .compare_output_out(pin), .compare_output_oe_out(pin_oe), .overflow_flag_out(ovf), .compare_flag_out(cmpf));
  tmw_load_model tmw_load_model_i (.ref_clk_in(ref_clk_in), .pin_in(pin), .pin_oe_in(pin_oe), .clr_in(clr),
    .line_out(line), .high_cnt_out(high_cnt));
  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One idle edge between strobes keeps each driver to one assignment per step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    #1;
    chk8(reg_rdata, exp);
  endtask
  task automatic measure(input int n, input logic [15:0] exp);
    @(posedge ref_clk_in);
    clr <= 1'b1;
    @(posedge ref_clk_in);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk_in);
    #1;
    chk16(high_cnt, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    wr(3'h6, 8'hff);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], 8'h00);
    end
    wr(tmw_pkg::ADDR_COMPARE, 8'h5a);
    rd(tmw_pkg::ADDR_COMPARE, 8'h5a);
    $display("test registers done");
    wr(tmw_pkg::ADDR_CTRL, 8'h80);
    wr(tmw_pkg::ADDR_PORT, 8'h01);
    #1 chk8({7'h00, line}, 8'h01);
    wr(tmw_pkg::ADDR_CTRL, 8'h00);
    #1 chk8({7'h00, line}, 8'h00);
    $display("test pin done");
    wr(tmw_pkg::ADDR_COMPARE, 8'h05);
    wr(tmw_pkg::ADDR_COUNT, 8'h0a);
    wr(tmw_pkg::ADDR_CTRL, 8'h12);
    repeat (100) @(posedge ref_clk_in);
    rd(tmw_pkg::ADDR_FLAGS, 8'h00);
    repeat (200) @(posedge ref_clk_in);
    rd(tmw_pkg::ADDR_FLAGS, 8'h03);
    chk8({6'h00, cmpf, ovf}, 8'h03);
    wr(tmw_pkg::ADDR_FLAGS, 8'h03);
    repeat (300) @(posedge ref_clk_in);
    rd(tmw_pkg::ADDR_FLAGS, 8'h02);
    chk8({6'h00, cmpf, ovf}, 8'h02);
    $display("test clear-on-match flags done");
    wr(tmw_pkg::ADDR_CTRL, 8'h96);
    for (int i = 0; i < 3; i++) begin
      wr(tmw_pkg::ADDR_COMPARE, ctc_c[i]);
      repeat (600) @(posedge ref_clk_in);
      measure(1000, 16'h01f4);
    end
    $display("test toggle done");
    for (int om = 1; om < 4; om++) begin
      for (int i = 0; i < 3; i++) begin
        wr(tmw_pkg::ADDR_CTRL, {4'h9, om[1:0], 2'h3});
        wr(tmw_pkg::ADDR_COMPARE, lvl[i]);
        hi = {7'h00, lvl[i], 1'b0} + 16'h0002;
        repeat (600) @(posedge ref_clk_in);
        measure(512, om == 1 ? 16'h0100 : om == 2 ? hi : 16'h0200 - hi);
      end
    end
    wr(tmw_pkg::ADDR_FLAGS, 8'h03);
    repeat (300) @(posedge ref_clk_in);
    rd(tmw_pkg::ADDR_FLAGS, 8'h03);
    $display("test fast pwm done");
    // Maximum first, so the next value exercises the forced level at the top
    for (int om = 2; om < 4; om++) begin
      for (int i = 0; i < 3; i++) begin
        wr(tmw_pkg::ADDR_CTRL, {4'h9, om[1:0], 2'h1});
        wr(tmw_pkg::ADDR_COMPARE, lvl[2 - i]);
        hi = {6'h00, lvl[2 - i], 2'h0};
        repeat (1200) @(posedge ref_clk_in);
        measure(1020, om == 2 ? hi : 16'h03fc - hi);
      end
    end
    wr(tmw_pkg::ADDR_FLAGS, 8'h03);
    repeat (600) @(posedge ref_clk_in);
    rd(tmw_pkg::ADDR_FLAGS, 8'h03);
    $display("test phase pwm done");
    for (int s = 1; s < 8; s++) begin
      wr(tmw_pkg::ADDR_CTRL, 8'h00);
      wr(tmw_pkg::ADDR_COUNT, 8'h00);
      wr(tmw_pkg::ADDR_CTRL, {1'b0, s[2:0], 4'h0});
      repeat (div_n[s - 1] * 4 + div_n[s - 1] / 2 - 1) @(posedge ref_clk_in);
      rd(tmw_pkg::ADDR_COUNT, 8'h04);
    end
    $display("test prescaler done");
    test_done();
  end
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    err_total++;
    test_done();
  end
endmodule
